// ### common/fpd_pkg.sv
// fixed_direction_port_handshake constants and carrier types
// assumes a byte-wide register file with separate read and write strobes
package fpd_pkg;
   localparam int DW = 8;
   localparam logic [7:0] DATA_ADDR = 8'h03;
   localparam logic [7:0] MODE_ADDR = 8'hF7;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   // mode register field positions
   localparam int MB_ANALOG = 1;
   localparam int MB_HS0 = 2;
   localparam int MB_HS1_LO = 3;
   localparam int MB_HS1_HI = 4;
   localparam int MB_HS2 = 6;
   // handshake channel to line mapping (input line index 0..3,
   // output line index 0..3 meaning lines 4..7)
   localparam int NCH = 3;
   localparam logic [1:0] HS_IN_LINE [NCH] = '{2'h2, 2'h3, 2'h1};
   localparam logic [1:0] HS_OUT_LINE [NCH] = '{2'h1, 2'h0, 2'h2};
   // interrupt request index driven by each input line
   localparam logic [1:0] IRQ_OF_LINE [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      FPD_IDLE,
      FPD_ACTIVE,
      FPD_WAIT
   } fpd_hs_e;

   // special function selects and values from the neighbouring blocks
   typedef struct packed {
      logic serial_en;
      logic timer_out_en;
      logic spi_en;
      logic ext_mem_en;
      logic cmp_out_en;
      logic serial_tx;
      logic timer_output;
      logic spi_serial_clock;
      logic spi_slave_sel;
      logic ext_memory_status;
      logic comparator_a_result;
      logic comparator_b_result;
   } fpd_sfn_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fpd_reg_req_s;
endpackage : fpd_pkg

// ### rtl/fpd_port.sv
// fixed-direction eight-line port with byte-port handshakes
// assumes register strobes are one-cycle pulses and that the byte ports
// (direction logic elsewhere) report their reads and writes here.
`timescale 1ns/1ps
module fpd_port #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire fpd_pkg::fpd_reg_req_s reg_req_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [3:0] in_line_i,
   output logic [3:0] out_line_o,
   output logic [3:0] int_request_o,
   output logic serial_receive_in_o,
   output logic timer_input_o,
   input wire fpd_pkg::fpd_sfn_s sfn_i,
   input wire logic [2:0] port_dir_out_i,
   input wire logic [2:0] port_rd_i,
   input wire logic [2:0] port_wr_i,
   input wire logic [W-1:0] port_pins_i [3],
   input wire logic [W-1:0] port_wdata_i [3],
   output logic [W-1:0] port_latch_o [3],
   output logic [W-1:0] port_drive_o [3]
);
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] prev_q;
   logic [3:0] fall;
   logic [7:0] out_reg_q;
   logic [7:0] mode_q;
   logic [7:0] rdata_q;
   logic [2:0] hs_en;
   logic [3:0] hs_drive;
   logic [3:0] hs_val;
   logic [3:0] sfn_drive;
   logic [3:0] sfn_val;
   logic [3:0] busy;
   logic [3:0] irq_line;
   logic [3:0] irq_q;
   logic data_wr;
   logic mode_wr;
   logic data_rd;

   // register decode
   assign data_wr = reg_req_i.wr && reg_req_i.addr == fpd_pkg::DATA_ADDR;
   assign mode_wr = reg_req_i.wr && reg_req_i.addr == fpd_pkg::MODE_ADDR;
   assign data_rd = reg_req_i.rd && reg_req_i.addr == fpd_pkg::DATA_ADDR;

   // handshake enables from the mode register; all zero is plain I/O
   assign hs_en[0] = mode_q[fpd_pkg::MB_HS0];
   assign hs_en[1] = mode_q[fpd_pkg::MB_HS1_LO] &&
                     mode_q[fpd_pkg::MB_HS1_HI];
   assign hs_en[2] = mode_q[fpd_pkg::MB_HS2];

   // two-stage synchroniser; only stage two feeds logic
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sync1_q <= 4'hF;
         sync2_q <= 4'hF;
         prev_q <= 4'hF;
      end else begin
         sync1_q <= in_line_i;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end
   assign fall = prev_q & ~sync2_q;

   // falling edges on each input line raise its mapped request; the
   // reference line cannot interrupt while the comparators are analog
   assign irq_line[0] = fall[0];
   assign irq_line[1] = fall[1];
   assign irq_line[2] = fall[2];
   assign irq_line[3] = fall[3] && !mode_q[fpd_pkg::MB_ANALOG];
   generate
      for (genvar l = 0; l < 4; l++) begin : g_irq
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               irq_q[fpd_pkg::IRQ_OF_LINE[l]] <= 1'b0;
            end else begin
               irq_q[fpd_pkg::IRQ_OF_LINE[l]] <= irq_line[l];
            end
         end
      end
   endgenerate
   assign int_request_o = irq_q;

   assign serial_receive_in_o = sync2_q[0];
   assign timer_input_o = sync2_q[1];

   // per-channel handshake engines
   logic [3:0] hs_drv_ch [3];
   logic [3:0] hs_val_ch [3];
   generate
      for (genvar c = 0; c < fpd_pkg::NCH; c++) begin : g_hs
         fpd_pkg::fpd_hs_e st_q;
         logic rd_seen_q;
         logic pend_q;
         logic [W-1:0] pend_data_q;
         logic [W-1:0] latch_q;
         logic [W-1:0] drive_q;
         logic strobe_in;
         logic strobe_fall;
         logic is_out;
         logic line_val;
         assign strobe_in = sync2_q[fpd_pkg::HS_IN_LINE[c]];
         assign strobe_fall = fall[fpd_pkg::HS_IN_LINE[c]];
         assign is_out = port_dir_out_i[c];
         // input side: ready high in idle; output side: strobe low active
         assign line_val = is_out ? (st_q != fpd_pkg::FPD_ACTIVE)
                                  : (st_q == fpd_pkg::FPD_IDLE);

         always_ff @(posedge clk_i) begin
            if (srst_i || !hs_en[c]) begin
               st_q <= fpd_pkg::FPD_IDLE;
               rd_seen_q <= 1'b0;
               pend_q <= 1'b0;
            end else if (!is_out) begin
               pend_q <= 1'b0;
               unique case (st_q)
                  fpd_pkg::FPD_IDLE: begin
                     rd_seen_q <= 1'b0;
                     if (strobe_fall) begin
                        st_q <= fpd_pkg::FPD_WAIT;
                     end
                  end
                  default: begin
                     // read may arrive with the strobe still low; keep it
                     if (port_rd_i[c]) begin
                        rd_seen_q <= 1'b1;
                     end
                     if ((rd_seen_q || port_rd_i[c]) && strobe_in) begin
                        st_q <= fpd_pkg::FPD_IDLE;
                     end
                  end
               endcase
            end else begin
               rd_seen_q <= 1'b0;
               unique case (st_q)
                  fpd_pkg::FPD_IDLE: begin
                     // ready input is the strobe line in output mode
                     if ((pend_q || port_wr_i[c]) && strobe_in) begin
                        st_q <= fpd_pkg::FPD_ACTIVE;
                     end
                     pend_q <= 1'b0;
                  end
                  fpd_pkg::FPD_ACTIVE: begin
                     if (port_wr_i[c]) begin
                        pend_q <= 1'b1;
                     end
                     if (!strobe_in) begin
                        st_q <= fpd_pkg::FPD_WAIT;
                     end
                  end
                  default: begin
                     if (port_wr_i[c]) begin
                        pend_q <= 1'b1;
                     end
                     if (strobe_in) begin
                        st_q <= fpd_pkg::FPD_IDLE;
                     end
                  end
               endcase
            end
         end

         // data paths kept out of the state process
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               latch_q <= '0;
            end else if (!hs_en[c] || is_out) begin
               latch_q <= port_pins_i[c];
            end else if (st_q == fpd_pkg::FPD_IDLE && strobe_fall) begin
               latch_q <= port_pins_i[c];
            end
         end
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               pend_data_q <= '0;
            end else if (port_wr_i[c]) begin
               pend_data_q <= port_wdata_i[c];
            end
         end
         // new data reaches the pins only while the interface is idle
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               drive_q <= '0;
            end else if (!hs_en[c] || st_q == fpd_pkg::FPD_IDLE) begin
               if (port_wr_i[c]) begin
                  drive_q <= port_wdata_i[c];
               end else if (pend_q) begin
                  drive_q <= pend_data_q;
               end
            end
         end
         assign port_latch_o[c] = latch_q;
         assign port_drive_o[c] = drive_q;
         assign hs_drv_ch[c] = hs_en[c] ?
            (4'h1 << fpd_pkg::HS_OUT_LINE[c]) : 4'h0;
         assign hs_val_ch[c] = line_val ?
            (4'h1 << fpd_pkg::HS_OUT_LINE[c]) : 4'h0;
      end
   endgenerate

   assign hs_drive = hs_drv_ch[0] | hs_drv_ch[1] | hs_drv_ch[2];
   assign hs_val = (hs_val_ch[0] & hs_drv_ch[0]) |
                   (hs_val_ch[1] & hs_drv_ch[1]) |
                   (hs_val_ch[2] & hs_drv_ch[2]);

   // special outputs; comparator results win over spi and memory status
   assign sfn_drive[0] = sfn_i.spi_en || sfn_i.ext_mem_en ||
                         sfn_i.cmp_out_en;
   assign sfn_val[0] = sfn_i.cmp_out_en ? sfn_i.comparator_a_result :
                       sfn_i.spi_en ? sfn_i.spi_serial_clock :
                       sfn_i.ext_memory_status;
   assign sfn_drive[1] = sfn_i.spi_en || sfn_i.cmp_out_en;
   assign sfn_val[1] = sfn_i.cmp_out_en ? sfn_i.comparator_b_result :
                       sfn_i.spi_slave_sel;
   assign sfn_drive[2] = sfn_i.timer_out_en;
   assign sfn_val[2] = sfn_i.timer_output;
   assign sfn_drive[3] = sfn_i.serial_en || sfn_i.cmp_out_en;
   assign sfn_val[3] = sfn_i.cmp_out_en ? sfn_i.comparator_b_result :
                       sfn_i.serial_tx;

   // handshake takes priority over any other special use of a line
   assign busy = hs_drive | sfn_drive;

   // shared output register; lines in special use keep stored bits,
   // so deselecting a function restores the previous pin value
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         out_reg_q <= fpd_pkg::DATA_RST;
      end else if (data_wr) begin
         out_reg_q[7:4] <= (reg_req_i.wdata[7:4] & ~busy) |
                           (out_reg_q[7:4] & busy);
      end
   end

   // write-only mode register; reset clears every handshake enable and the analog select
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_q <= fpd_pkg::MODE_RST;
      end else if (mode_wr) begin
         mode_q <= reg_req_i.wdata;
      end
   end

   // one-cycle read latency; unmapped and mode reads return zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
      end else if (data_rd) begin
         rdata_q <= {out_reg_q[7:4], sync2_q};
      end else if (reg_req_i.rd) begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata_o = rdata_q;

   // lines 0..3 only ever sense; lines 4..7 only ever drive
   assign out_line_o = (hs_drive & hs_val) |
                       (~hs_drive & sfn_drive & sfn_val) |
                       (~busy & out_reg_q[7:4]);
endmodule : fpd_port

// ### tb/fpd_periph.sv
// peripheral on the byte port 0 handshake, sender or receiver
// assumes send is called only while rx_en_i is low
`timescale 1ns/1ps
module fpd_periph (
   input wire logic clk_i,
   input wire logic dev_line_i,
   input wire logic [7:0] dev_data_i,
   input wire logic rx_en_i,
   output logic line_o,
   output logic [7:0] pins_o,
   output logic [7:0] got_o
);
   int slow = 0;
   initial begin
      line_o = 1'b1;
      pins_o = 8'hFF;
      got_o = 8'h00;
   end
   task automatic send(input logic [7:0] b);
      pins_o = b;
      line_o = 1'b0;
      for (int i = 0; i < 40 && dev_line_i; i++) @(posedge clk_i) #1;
      repeat (slow + 2) @(posedge clk_i) #1;
      line_o = 1'b1;
      pins_o = ~b; // stale byte inverted so it never passes as valid
   endtask : send
   // receiver: ready low once latched, high only after strobe is back
   always @(posedge clk_i) begin
      #1;
      if (rx_en_i && !dev_line_i && line_o) begin
         got_o = dev_data_i;
         repeat (slow) @(posedge clk_i) #1;
         line_o = 1'b0;
         for (int i = 0; i < 40 && !dev_line_i; i++) @(posedge clk_i) #1;
         line_o = 1'b1;
      end
   end
endmodule : fpd_periph

// ### tb/fpd_port_props.sv
// checker on the fixed-direction port top-level ports
// assumes single clock domain, sync reset high
`timescale 1ns/1ps
module fpd_port_props #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire fpd_pkg::fpd_reg_req_s reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [3:0] in_line_i,
   input wire logic [3:0] out_line_o,
   input wire logic [3:0] int_request_o,
   input wire fpd_pkg::fpd_sfn_s sfn_i,
   input wire logic [2:0] port_dir_out_i,
   input wire logic [2:0] port_wr_i,
   input wire logic [W-1:0] port_wdata_i [3],
   input wire logic [W-1:0] port_drive_o [3]
);
   logic [7:0] mode_q;
   wire wr_mode = reg_req_i.wr && reg_req_i.addr == fpd_pkg::MODE_ADDR;
   wire wr_data = reg_req_i.wr && reg_req_i.addr == fpd_pkg::DATA_ADDR;
   wire plain = mode_q == 8'h00 && sfn_i == '0;
   wire hs_in = mode_q[2] && !port_dir_out_i[0];
   wire hs_out = mode_q[2] && port_dir_out_i[0];
   // mode cannot be read back, so keep a shadow copy
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_q <= 8'h00;
      end else if (wr_mode) begin
         mode_q <= reg_req_i.wdata;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   sequence s_rdy_fell;
      hs_out && !out_line_o[1] && $fell(in_line_i[2]);
   endsequence
   property p_rst;
      $fell(srst_i) |-> int_request_o == 4'h0 && reg_rdata_o == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_irq;
      $fell(in_line_i[0]) |-> ##[1:5] int_request_o[3];
   endproperty
   a_irq: assert property (p_irq) else $error("no int_request_three");
   property p_wr;
      wr_data && plain |=> out_line_o == $past(reg_req_i.wdata[7:4]);
   endproperty
   a_wr: assert property (p_wr) else $error("data write");
   property p_rdy_lo;
      hs_in && out_line_o[1] && $fell(in_line_i[2]) |-> ##[2:4] !out_line_o[1];
   endproperty
   a_rdy_lo: assert property (p_rdy_lo) else $error("ready");
   property p_rdy_hi;
      hs_in && $past(hs_in) && $rose(out_line_o[1])
         |-> $past(in_line_i[2]) && $past(in_line_i[2], 2);
   endproperty
   a_rdy_hi: assert property (p_rdy_hi) else $error("early ready");
   property p_out;
      port_wr_i[0] && hs_out && out_line_o[1] && in_line_i[2]
         && $past(in_line_i[2], 3)
         |=> !out_line_o[1] && port_drive_o[0] == $past(port_wdata_i[0]);
   endproperty
   a_out: assert property (p_out) else $error("out start");
   property p_str;
      s_rdy_fell |-> ##[1:4] out_line_o[1];
   endproperty
   a_str: assert property (p_str) else $error("strobe stuck");
   property p_int;
      s_rdy_fell |-> ##[1:6] int_request_o[0];
   endproperty
   a_int: assert property (p_int) else $error("no int_request_zero");
endmodule : fpd_port_props
bind fpd_port fpd_port_props #(.W(W)) chk_u (.clk_i, .srst_i, .reg_req_i,
   .reg_rdata_o, .in_line_i, .out_line_o, .int_request_o, .sfn_i,
   .port_dir_out_i, .port_wr_i, .port_wdata_i, .port_drive_o);

// ### tb/tb_top.sv
// self-checking bench for the fixed-direction port
// assumes peripheral on byte port 0; bench strobes byte ports 1 and 2
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   fpd_pkg::fpd_reg_req_s req = '0;
   logic [7:0] rdata, p_pins, got;
   logic [7:0] pins [3], wdat [3], latch [3], drv [3];
   logic [3:0] tb_line = 4'hF;
   logic [3:0] out_line, irq;
   logic [2:0] dir = 3'h0;
   logic [2:0] prd = 3'h0;
   logic [2:0] pwr = 3'h0;
   logic p_line;
   logic rx_en = 1'b0;
   logic ser, tmr;
   logic [7:0] pin12 = 8'h00;
   fpd_pkg::fpd_sfn_s sfn = '0;
   int failures = 0;
   int num_checks = 0;
   int n;
   int irq_of [4] = '{3, 2, 0, 1};
   always #4 clk_i = ~clk_i;
   assign pins[0] = p_pins;
   assign pins[1] = pin12;
   assign pins[2] = ~pin12;
   initial wdat = '{8'h00, 8'h00, 8'h00};
   fpd_port dut_u (.clk_i(clk_i), .srst_i(srst_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .in_line_i({tb_line[3], p_line, tb_line[1:0]}),
      .out_line_o(out_line), .int_request_o(irq), .serial_receive_in_o(ser),
      .timer_input_o(tmr), .sfn_i(sfn), .port_dir_out_i(dir), .port_rd_i(prd),
      .port_wr_i(pwr), .port_pins_i(pins), .port_wdata_i(wdat),
      .port_latch_o(latch), .port_drive_o(drv));
   fpd_periph periph_u (.clk_i(clk_i), .dev_line_i(out_line[1]),
      .dev_data_i(drv[0]), .rx_en_i(rx_en), .line_o(p_line),
      .pins_o(p_pins), .got_o(got));
   task automatic step;
      @(posedge clk_i) #1;
   endtask : step
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // a bound that runs out ends the run at once
   task automatic lim;
      num_checks++;
      if (n >= 80) begin
         failures++;
         $display("mismatch at %0t: wait expired", $time);
         tally_and_finish();
      end
   endtask : lim
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      step;
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      step;
      req.wr = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      step;
      req.rd = 1'b1;
      req.addr = a;
      step;
      req.rd = 1'b0;
      chk(rdata, e);
   endtask : reg_rd
   task automatic port_wr(input int c, input logic [7:0] d);
      step;
      wdat[c] = d;
      pwr[c] = 1'b1;
      step;
      pwr[c] = 1'b0;
   endtask : port_wr
   task automatic wait_irq(input int k);
      for (n = 0; n < 80 && irq[k] !== 1'b1; n++) step;
      lim();
   endtask : wait_irq
   task automatic wait_rdy(input int k, input logic v);
      for (n = 0; n < 80 && out_line[k] !== v; n++) step;
      lim();
   endtask : wait_rdy
   initial begin
      repeat (5) step;
      srst_i = 1'b0;
      reg_rd(8'h03, 8'h0F);
      chk({4'h0, out_line}, 8'h00);
      reg_rd(8'hF7, 8'h00);
      reg_rd(8'h55, 8'h00);
      for (int i = 0; i < 4; i++) begin
         if (i != 2) begin
            tb_line[i] = 1'b0;
            wait_irq(irq_of[i]);
         end
      end
      reg_wr(8'h03, 8'hA5);
      chk({4'h0, out_line}, 8'h0A);
      reg_rd(8'h03, 8'hA4);
      tb_line = 4'hF;
      step;
      chk({6'h0, ser, tmr}, 8'h00);
      step;
      chk({6'h0, ser, tmr}, 8'h03);
      sfn = '{cmp_out_en: 1'b1, comparator_a_result: 1'b1, default: 1'b0};
      step;
      chk({4'h0, out_line}, 8'h01);
      reg_wr(8'h03, 8'hF0);
      chk({4'h0, out_line}, 8'h05);
      reg_rd(8'h03, 8'hEF);
      sfn = '0;
      step;
      chk({4'h0, out_line}, 8'h0E);
      sfn = '{serial_en: 1'b1, timer_out_en: 1'b1, spi_en: 1'b1,
         spi_serial_clock: 1'b1, default: 1'b0};
      step;
      chk({4'h0, out_line}, 8'h01);
      sfn = '{ext_mem_en: 1'b1, ext_memory_status: 1'b1, default: 1'b0};
      step;
      chk({4'h0, out_line}, 8'h0F);
      sfn = '0;
      reg_wr(8'h03, 8'h20);
      reg_wr(8'hF7, 8'h04);
      periph_u.send(8'h3C);
      chk(latch[0], 8'h3C);
      chk({7'h0, out_line[1]}, 8'h00);
      periph_u.send(8'hC3);
      repeat (4) step;
      chk(latch[0], 8'h3C);
      chk({7'h0, out_line[1]}, 8'h00);
      step;
      prd[0] = 1'b1;
      step;
      prd[0] = 1'b0;
      wait_rdy(1, 1'b1);
      reg_wr(8'h03, 8'h00);
      chk({7'h0, out_line[1]}, 8'h01);
      reg_wr(8'hF7, 8'h00);
      dir[0] = 1'b1;
      reg_wr(8'hF7, 8'h04);
      rx_en = 1'b1;
      repeat (4) step;
      port_wr(0, 8'h5A);
      chk(drv[0], 8'h5A);
      chk({7'h0, out_line[1]}, 8'h00);
      wait_irq(0);
      chk(got, 8'h5A);
      periph_u.slow = 6;
      repeat (8) step;
      port_wr(0, 8'h11);
      port_wr(0, 8'h22);
      chk(drv[0], 8'h11);
      for (n = 0; n < 80 && got !== 8'h22; n++) step;
      lim();
      // let the held-back transfer finish before the engine is switched off
      repeat (16) step;
      rx_en = 1'b0;
      reg_wr(8'hF7, 8'h00);
      dir[0] = 1'b0;
      port_wr(1, 8'hA6);
      chk(drv[1], 8'hA6);
      port_wr(2, 8'h6A);
      chk(drv[2], 8'h6A);
      reg_wr(8'h03, 8'h70);
      reg_wr(8'hF7, 8'h58);
      chk({4'h0, out_line}, 8'h07);
      pin12 = 8'h96;
      tb_line[3] = 1'b0;
      wait_rdy(0, 1'b0);
      chk({4'h0, out_line}, 8'h06);
      chk(latch[1], 8'h96);
      pin12 = 8'h3C;
      tb_line[3] = 1'b1;
      prd[1] = 1'b1;
      step;
      prd[1] = 1'b0;
      chk(latch[1], 8'h96);
      wait_rdy(0, 1'b1);
      tb_line[1] = 1'b0;
      wait_rdy(2, 1'b0);
      chk(latch[2], 8'hC3);
      tb_line[1] = 1'b1;
      prd[2] = 1'b1;
      step;
      prd[2] = 1'b0;
      wait_rdy(2, 1'b1);
      tally_and_finish();
   end
endmodule : tb_top
